// [src/tmon_averager.sv]
// tmon_averager.sv - link-side converter control and sample averaging
// assumes: front end delivers one sample per fe_valid on sample_clk
`timescale 1ns/1ns
module tmon_averager import tmon_pkg::*; #(
	parameter int SAMPLES = AVG_SAMPLES
) (
	input wire logic sample_clk,
	input wire logic resetn,
	tmon_conv_if.avg conv,
	output logic fe_enable,
	output logic fe_remote_sel,
	input wire logic fe_valid,
	input wire logic [7:0] fe_data,
	input wire logic fe_open
);
	localparam int LG = $clog2(SAMPLES);
	generate
		if (SAMPLES < 2 || (1 << LG) != SAMPLES)
			$error("sample count must be a power of two");
	endgenerate
	// ----------------------------------------
	// crossings into the link domain
	// ----------------------------------------
	logic rst_s1, rst_s2; // reset brought onto sample_clk
	logic req_s1, req_s2; // request toggle synchroniser
	always_ff @(posedge sample_clk)
	begin
		rst_s1 <= resetn;
		rst_s2 <= rst_s1;
		req_s1 <= conv.req_tog;
		req_s2 <= req_s1;
	end
	// ----------------------------------------
	// averaging state
	// ----------------------------------------
	logic busy, next_busy; // accumulating a result
	logic seen, next_seen; // last request toggle served
	logic sel, next_sel; // channel being measured
	logic [LG-1:0] count, next_count; // samples taken so far
	logic [LG+7:0] sum, next_sum; // signed running sum
	logic [7:0] result, next_result;
	logic open, next_open, res_open, next_res_open;
	logic ack, next_ack;
	logic [7:0] avg; // floor of the mean
	// mean of the window, held to the valid range
	always_comb
	begin
		next_busy = busy;
		next_seen = seen;
		next_sel = sel;
		next_count = count;
		next_sum = sum;
		next_result = result;
		next_open = open;
		next_res_open = res_open;
		next_ack = ack;
		avg = 8'h00;
		if (!busy && req_s2 != seen)
		begin
			// remote_sel is stable here: core holds it across the handshake
			next_busy = 1'b1;
			next_seen = req_s2;
			next_sel = conv.remote_sel;
			next_count = '0;
			next_sum = '0;
			next_open = 1'b0;
		end
		else if (busy && fe_valid)
		begin
			next_sum = sum + (LG+8)'($signed(fe_data));
			next_open = open | fe_open;
			next_count = count + 1'b1;
			if (count == LG'(SAMPLES - 1))
			begin
				avg = next_sum[LG+7:LG];
				// floor the reading at the lowest measurable code
				next_result = ($signed(avg) < $signed(TEMP_MIN_VALID)) ? TEMP_MIN_VALID : avg;
				next_res_open = next_open;
				next_busy = 1'b0;
				next_ack = ~ack;
			end
		end
	end
	// register the averaging state
	always_ff @(posedge sample_clk)
	begin
		if (!rst_s2)
		begin
			busy <= 1'b0;
			seen <= 1'b0;
			sel <= 1'b0;
			count <= '0;
			sum <= '0;
			result <= TEMP_RESET;
			open <= 1'b0;
			res_open <= 1'b0;
			ack <= 1'b0;
		end
		else
		begin
			busy <= next_busy;
			seen <= next_seen;
			sel <= next_sel;
			count <= next_count;
			sum <= next_sum;
			result <= next_result;
			open <= next_open;
			res_open <= next_res_open;
			ack <= next_ack;
		end
	end
	assign fe_enable = busy;
	assign fe_remote_sel = sel;
	assign conv.ack_tog = ack;
	assign conv.result = result;
	assign conv.open_flag = res_open;
	// a result is only handed over after the full window
	a_avg_window: assert property (@(posedge sample_clk) disable iff (!rst_s2)
		$changed(ack) |-> $past(busy) && $past(fe_valid) && $past(count) == LG'(SAMPLES - 1))
		else $error("result handed over before full window");
endmodule

// [src/tmon_conv_if.sv]
// tmon_conv_if.sv - request and result bundle between core and averager
// assumes: req_tog and remote_sel on mclk, result side on sample_clk
`timescale 1ns/1ns
interface tmon_conv_if;
	logic req_tog; // toggles once per requested conversion
	logic remote_sel; // channel asked for, held while request pending
	logic ack_tog; // toggles when result and open_flag are ready
	logic [7:0] result; // averaged temperature, held until the next result is ready
	logic open_flag; // sensor open seen during the average
	modport core (output req_tog, output remote_sel, input ack_tog, input result,
		input open_flag);
	modport avg (input req_tog, input remote_sel, output ack_tog, output result,
		output open_flag);
endinterface

// [src/tmon_core.sv]
// tmon_core.sv - two channel temperature monitor digital core
// assumes: smbus pins and standby pin asynchronous to mclk, front end on sample_clk
// What this block does
// - converts continuously, alternating local and remote
// - stores each result in its channel register
// - compares values to four limits, sets flags
// - any set flag pulls alert low
// - limits and control writable, everything readable
// - host controls standby, alert suppress, rate
// - value registers reset to minus 128
// - normal power-up compares only after both measured
// - standby power-up compares defaults, trips under flags
// - leaving standby clears only if values in range
// - each result averages sixteen samples
// - one degree per lsb, two's complement
// - valid results span minus 65 to 127
// - nine registers: values, limits, control, status
// - separate read and write addresses
// - first written byte loads the index pointer
// - pointer selects write target and later reads
// - status read clears flags no longer true
// - status: busy, four limit flags, open
// - standby bit or pin stops; mask bit suppresses
// - alert response releases latch once all clear
`timescale 1ns/1ns
module tmon_core import tmon_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a, // bus address
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] REVISION_ID = 8'h01, // arbitrary value
	parameter int CONV_CYCLES = CONV_BASE_CYCLES // fastest conversion period
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sample_clk,
	input wire logic smb_scl_in,
	input wire logic smb_sda_in,
	output logic smb_sda_out,
	output logic smb_sda_oe,
	input wire logic alert_n_in,
	output logic alert_n_out,
	output logic alert_n_oe,
	input wire logic standby_request_n,
	output logic fe_enable,
	output logic fe_remote_sel,
	input wire logic fe_valid,
	input wire logic [7:0] fe_data,
	input wire logic fe_open
);
	generate
		if (CONV_CYCLES < 1 || CONV_CYCLES > 16777215)
			$error("conversion period out of range");
	endgenerate
	// ----------------------------------------
	// pin and handshake synchronisers
	// ----------------------------------------
	tmon_conv_if conv(); // request and result bundle to the link side
	logic [3:0] sy1, sy2; // {ack, standby_n, sda, scl}
	logic scl_d, sda_d; // previous synced levels for edges
	always_ff @(posedge mclk)
	begin
		sy1 <= {conv.ack_tog, standby_request_n, smb_sda_in, smb_scl_in};
		sy2 <= sy1;
		scl_d <= sy2[0];
		sda_d <= sy2[1];
	end
	wire scl_rise = sy2[0] & ~scl_d;
	wire scl_fall = ~sy2[0] & scl_d;
	wire bus_start = sy2[0] & scl_d & sda_d & ~sy2[1];
	wire bus_stop = sy2[0] & scl_d & ~sda_d & sy2[1];
	// ----------------------------------------
	// registers and shared signals
	// ----------------------------------------
	logic [7:0] index_pointer, cfg, rate, lhi, llo, rhi, rlo, local_val, remote_val;
	logic [FLAG_COUNT-1:0] flags; // sticky out-of-limit and open flags
	logic [FLAG_COUNT-1:0] cond; // live conditions from stored values
	logic remote_open; // open seen on last remote result
	logic alert_latch;
	logic ptr_load, reg_write, status_read, ara_done; // bus events, one cycle
	logic [7:0] rx_byte; // byte just received
	logic conv_busy, store_local, store_remote, cmp_pend, pu_cmp;
	logic [7:0] rd_data;
	logic alert_live;
	tmon_averager #(.SAMPLES(AVG_SAMPLES)) u_avg (
		.sample_clk(sample_clk),
		.resetn(resetn),
		.conv(conv),
		.fe_enable(fe_enable),
		.fe_remote_sel(fe_remote_sel),
		.fe_valid(fe_valid),
		.fe_data(fe_data),
		.fe_open(fe_open)
	);
	// limit comparators on the stored values
	assign cond = {$signed(local_val) > $signed(lhi), $signed(local_val) < $signed(llo),
		$signed(remote_val) > $signed(rhi), $signed(remote_val) < $signed(rlo),
		remote_open};
	assign alert_live = alert_latch & ~cfg[CFG_ALERT_SUPPRESS];
	// read decode uses the read addresses only
	always_comb
	begin
		case (index_pointer)
			RD_LOCAL: rd_data = local_val;
			RD_REMOTE: rd_data = remote_val;
			RD_STATUS: rd_data = {conv_busy, flags, 2'b00};
			RD_CONFIG: rd_data = cfg;
			RD_RATE: rd_data = rate;
			RD_LOCAL_HI: rd_data = lhi;
			RD_LOCAL_LO: rd_data = llo;
			RD_REMOTE_HI: rd_data = rhi;
			RD_REMOTE_LO: rd_data = rlo;
			RD_MAKER_ID: rd_data = MAKER_ID;
			RD_REVISION: rd_data = REVISION_ID;
			default: rd_data = UNMAPPED_READ;
		endcase
	end
	// ----------------------------------------
	// smbus slave
	// ----------------------------------------
	tmon_smb_state_type smb, next_smb;
	logic [3:0] bits, next_bits; // scl rises in current byte
	logic [7:0] shreg, next_shreg; // receive and transmit shifter
	logic rw, next_rw, ara, next_ara, first, next_first;
	logic drive, next_drive; // pull sda low
	logic load_tx; // fetch next read byte
	always_comb
	begin
		next_smb = smb;
		next_bits = bits;
		next_shreg = shreg;
		next_rw = rw;
		next_ara = ara;
		next_first = first;
		next_drive = drive;
		ptr_load = 1'b0;
		reg_write = 1'b0;
		load_tx = 1'b0;
		if (bus_start)
		begin
			// a repeated start also lands here
			next_smb = SMB_ADDR;
			next_bits = 4'h0;
			next_drive = 1'b0;
			next_first = 1'b1;
		end
		else if (bus_stop)
		begin
			next_smb = SMB_IDLE;
			next_drive = 1'b0;
		end
		else
		begin
			case (smb)
				SMB_ADDR, SMB_WBYTE:
				begin
					if (scl_rise)
					begin
						next_shreg = {shreg[6:0], sy2[1]};
						next_bits = bits + 4'h1;
					end
					if (scl_fall && bits == 4'h8 && smb == SMB_ADDR)
					begin
						next_rw = shreg[0];
						next_ara = 1'b0;
						next_drive = 1'b1;
						next_smb = SMB_ADDR_ACK;
						if (shreg == {ALERT_RESPONSE_ADDR, 1'b1} && alert_live)
							next_ara = 1'b1;
						else if (shreg[7:1] != SLAVE_ADDR)
						begin
							// not ours: stay off the bus until next start
							next_drive = 1'b0;
							next_smb = SMB_IDLE;
						end
					end
					else if (scl_fall && bits == 4'h8)
					begin
						ptr_load = first;
						reg_write = ~first;
						next_first = 1'b0;
						next_drive = 1'b1;
						next_smb = SMB_WACK;
					end
				end
				SMB_ADDR_ACK, SMB_WACK:
				begin
					if (scl_fall)
					begin
						next_bits = 4'h0;
						next_drive = 1'b0;
						next_smb = SMB_WBYTE;
						load_tx = rw && smb == SMB_ADDR_ACK;
					end
				end
				SMB_RBYTE:
				begin
					if (scl_rise)
						next_bits = bits + 4'h1;
					if (scl_fall && bits == 4'h8)
					begin
						next_drive = 1'b0;
						next_smb = SMB_RACK;
					end
					else if (scl_fall)
					begin
						next_shreg = {shreg[6:0], 1'b0};
						next_drive = ~shreg[6];
					end
				end
				SMB_RACK:
				begin
					// a nack from the host ends the read
					if (scl_rise && sy2[1])
						next_smb = SMB_IDLE;
					else if (scl_fall && ara)
						next_smb = SMB_IDLE;
					else if (scl_fall)
					begin
						next_bits = 4'h0;
						load_tx = 1'b1;
					end
				end
				default: next_smb = SMB_IDLE;
			endcase
		end
		if (load_tx)
		begin
			next_shreg = ara ? {SLAVE_ADDR, 1'b0} : rd_data;
			next_drive = ~next_shreg[7];
			next_smb = SMB_RBYTE;
		end
	end
	assign status_read = load_tx & ~ara & (index_pointer == RD_STATUS);
	assign ara_done = load_tx & ara;
	assign rx_byte = shreg;
	// register the slave state
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			smb <= SMB_IDLE;
			bits <= 4'h0;
			shreg <= 8'h00;
			rw <= 1'b0;
			ara <= 1'b0;
			first <= 1'b0;
			drive <= 1'b0;
		end
		else
		begin
			smb <= next_smb;
			bits <= next_bits;
			shreg <= next_shreg;
			rw <= next_rw;
			ara <= next_ara;
			first <= next_first;
			drive <= next_drive;
		end
	end
	assign smb_sda_out = 1'b0;
	assign smb_sda_oe = ~drive;
	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	tmon_conv_state_type cst, next_cst;
	logic [31:0] timer, next_timer; // cycles to next pair
	logic req, next_req, rsel, next_rsel, ack_d;
	logic oneshot, next_oneshot; // single pair requested
	logic [1:0] pu_wait, next_pu_wait; // lets the standby pin settle
	logic standby;
	logic [2:0] rate_eff;
	wire ack_edge = sy2[3] ^ ack_d;
	assign standby = cfg[CFG_STANDBY] | ~sy2[2];
	// reserved rate codes run at the fastest rate
	assign rate_eff = (rate > {5'h00, RATE_MAX}) ? RATE_MAX : rate[2:0];
	assign store_local = cst == CONV_LOCAL && ack_edge;
	assign store_remote = cst == CONV_REMOTE && ack_edge;
	assign conv_busy = cst != CONV_IDLE;
	always_comb
	begin
		next_cst = cst;
		next_req = req;
		next_rsel = rsel;
		next_oneshot = oneshot | (reg_write && index_pointer == WR_ONESHOT);
		next_timer = (timer != 32'h0) ? timer - 32'h1 : timer;
		next_pu_wait = (pu_wait != POWERUP_SETTLE) ? pu_wait + 2'h1 : pu_wait;
		pu_cmp = pu_wait == 2'h2 && standby;
		case (cst)
			CONV_IDLE:
			begin
				if (pu_wait == POWERUP_SETTLE && ((timer == 32'h0 && !standby) || oneshot))
				begin
					next_req = ~req;
					next_rsel = 1'b0;
					next_oneshot = 1'b0;
					next_timer = 32'(CONV_CYCLES) << (RATE_MAX - rate_eff);
					next_cst = CONV_LOCAL;
				end
			end
			CONV_LOCAL:
			begin
				if (ack_edge)
				begin
					next_req = ~req;
					next_rsel = 1'b1;
					next_cst = CONV_REMOTE;
				end
			end
			CONV_REMOTE:
			begin
				if (ack_edge)
					next_cst = CONV_IDLE;
			end
			default: next_cst = CONV_IDLE;
		endcase
	end
	// register the sequencer
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			cst <= CONV_IDLE;
			timer <= 32'h0;
			req <= 1'b0;
			rsel <= 1'b0;
			ack_d <= 1'b0;
			oneshot <= 1'b0;
			pu_wait <= 2'h0;
			cmp_pend <= 1'b0;
		end
		else
		begin
			cst <= next_cst;
			timer <= next_timer;
			req <= next_req;
			rsel <= next_rsel;
			ack_d <= sy2[3];
			oneshot <= next_oneshot;
			pu_wait <= next_pu_wait;
			cmp_pend <= store_remote | pu_cmp;
		end
	end
	assign conv.req_tog = req;
	assign conv.remote_sel = rsel;
	// ----------------------------------------
	// register bank, flags and alert
	// ----------------------------------------
	logic [7:0] next_ptr, next_cfg, next_rate, next_lhi, next_llo, next_rhi, next_rlo;
	logic [7:0] next_local, next_remote;
	logic [FLAG_COUNT-1:0] next_flags;
	logic next_open, next_latch;
	always_comb
	begin
		next_ptr = ptr_load ? rx_byte : index_pointer;
		next_cfg = (reg_write && index_pointer == WR_CONFIG) ? rx_byte : cfg;
		next_rate = (reg_write && index_pointer == WR_RATE) ? rx_byte : rate;
		next_lhi = (reg_write && index_pointer == WR_LOCAL_HI) ? rx_byte : lhi;
		next_llo = (reg_write && index_pointer == WR_LOCAL_LO) ? rx_byte : llo;
		next_rhi = (reg_write && index_pointer == WR_REMOTE_HI) ? rx_byte : rhi;
		next_rlo = (reg_write && index_pointer == WR_REMOTE_LO) ? rx_byte : rlo;
		next_local = store_local ? conv.result : local_val;
		next_remote = store_remote ? conv.result : remote_val;
		next_open = store_remote ? conv.open_flag : remote_open;
		// clear only what no longer holds, then let a new compare win
		next_flags = status_read ? (flags & cond) : flags;
		if (cmp_pend)
			next_flags = next_flags | cond;
		// release needs the response read and every flag gone
		next_latch = (alert_latch & ~(ara_done && flags == '0)) | (|flags);
	end
	// register the bank
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			index_pointer <= 8'h00;
			cfg <= CONFIG_RESET;
			rate <= RATE_RESET;
			lhi <= HI_LIMIT_RESET;
			llo <= LO_LIMIT_RESET;
			rhi <= HI_LIMIT_RESET;
			rlo <= LO_LIMIT_RESET;
			local_val <= TEMP_RESET;
			remote_val <= TEMP_RESET;
			remote_open <= 1'b0;
			flags <= '0;
			alert_latch <= 1'b0;
			alert_n_oe <= 1'b1;
		end
		else
		begin
			index_pointer <= next_ptr;
			cfg <= next_cfg;
			rate <= next_rate;
			lhi <= next_lhi;
			llo <= next_llo;
			rhi <= next_rhi;
			rlo <= next_rlo;
			local_val <= next_local;
			remote_val <= next_remote;
			remote_open <= next_open;
			flags <= next_flags;
			alert_latch <= next_latch;
			alert_n_oe <= ~alert_live;
		end
	end
	assign alert_n_out = 1'b0;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_value_reset: assert property ($rose(resetn) |-> local_val == TEMP_RESET && remote_val == TEMP_RESET)
		else $error("value registers not at reset code");
	a_channel_order: assert property (store_local |=> cst == CONV_REMOTE && rsel && req != $past(req))
		else $error("remote not requested after local");
	a_value_range: assert property (store_remote |=> $signed(remote_val) >= $signed(TEMP_MIN_VALID))
		else $error("stored remote value below valid range");
	a_flag_persist: assert property (status_read |=> (flags & $past(flags) & $past(cond)) == ($past(flags) & $past(cond)))
		else $error("persisting flag cleared by status read");
	a_flag_latch: assert property ((|flags) |=> alert_latch)
		else $error("flag did not set alert latch");
	a_alert_pin: assert property (alert_latch && !cfg[CFG_ALERT_SUPPRESS] |=> !alert_n_oe)
		else $error("alert pin not driven while latched");
	a_pointer_load: assert property (ptr_load |=> index_pointer == $past(rx_byte))
		else $error("pointer not loaded from first byte");
	a_standby_hold: assert property (cst == CONV_IDLE && standby && !oneshot && !reg_write |=> cst == CONV_IDLE)
		else $error("conversion started in standby");
endmodule

// [src/tmon_pkg.sv]
// tmon_pkg.sv - constants and types shared by the temperature monitor core
// assumes: mclk at 125 MHz, 8-bit two's complement temperature codes
package tmon_pkg;
	// ----------------------------------------
	// register read and write addresses
	// ----------------------------------------
	localparam logic [7:0] RD_LOCAL = 8'h00;
	localparam logic [7:0] RD_REMOTE = 8'h01;
	localparam logic [7:0] RD_STATUS = 8'h02;
	localparam logic [7:0] RD_CONFIG = 8'h03;
	localparam logic [7:0] RD_RATE = 8'h04;
	localparam logic [7:0] RD_LOCAL_HI = 8'h05;
	localparam logic [7:0] RD_LOCAL_LO = 8'h06;
	localparam logic [7:0] RD_REMOTE_HI = 8'h07;
	localparam logic [7:0] RD_REMOTE_LO = 8'h08;
	localparam logic [7:0] WR_CONFIG = 8'h09;
	localparam logic [7:0] WR_RATE = 8'h0a;
	localparam logic [7:0] WR_LOCAL_HI = 8'h0b;
	localparam logic [7:0] WR_LOCAL_LO = 8'h0c;
	localparam logic [7:0] WR_REMOTE_HI = 8'h0d;
	localparam logic [7:0] WR_REMOTE_LO = 8'h0e;
	localparam logic [7:0] WR_ONESHOT = 8'h0f;
	localparam logic [7:0] RD_MAKER_ID = 8'hfe;
	localparam logic [7:0] RD_REVISION = 8'hff;
	localparam logic [7:0] UNMAPPED_READ = 8'hff;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] TEMP_RESET = 8'h80;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [7:0] HI_LIMIT_RESET = 8'h7f;
	localparam logic [7:0] LO_LIMIT_RESET = 8'hc9;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int STAT_BUSY = 7;
	localparam int STAT_FLAGS_LSB = 2;
	localparam int CFG_ALERT_SUPPRESS = 7;
	localparam int CFG_STANDBY = 6;
	// flag vector order: local over, local under, remote over, remote under, open
	localparam int FLAG_COUNT = 5;
	// ----------------------------------------
	// codes and timing
	// ----------------------------------------
	localparam logic [7:0] TEMP_MIN_VALID = 8'hbf;
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
	localparam logic [2:0] RATE_MAX = 3'h7;
	localparam int AVG_SAMPLES = 16;
	localparam int MCLK_MHZ = 125;
	localparam int CONV_BASE_MS = 125;
	localparam int CONV_BASE_CYCLES = CONV_BASE_MS * 1000 * MCLK_MHZ;
	localparam logic [1:0] POWERUP_SETTLE = 2'h3;
	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum {SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_WBYTE, SMB_WACK, SMB_RBYTE, SMB_RACK}
		tmon_smb_state_type;
	typedef enum {CONV_IDLE, CONV_LOCAL, CONV_REMOTE} tmon_conv_state_type;
endpackage

// [tb/dual_channel_temp_monitor_tb.sv]
// dual_channel_temp_monitor_tb.sv - smbus level test of the monitor core
// assumes: pull-ups on sda and alert, front end from tmon_fe_model
`timescale 1ns/1ns
module dual_channel_temp_monitor_tb import tmon_pkg::*; ();
	localparam logic [6:0] ADDR = 7'h2a;
	logic mclk = 1'b0, sample_clk = 1'b0, resetn = 1'b0, scl = 1'b1, sda = 1'b1, standby_request_n_n = 1'b0;
	logic sda_out, sda_oe, alert_out, alert_oe, fe_en, fe_rsel, fe_valid, fe_open, open_t = 1'b0;
	logic [7:0] fe_data, rdat, local_t = 8'h19, remote_t = 8'h9c;
	logic [7:0] rst_val [6] = '{8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
	int failures = 0, check_count = 0;
	wire logic sda_line = sda & sda_oe; // wired-and with pull-up
	initial forever #4 mclk = ~mclk;
	initial
	begin
		#3;
		forever #32 sample_clk = ~sample_clk;
	end
	tmon_core #(.SLAVE_ADDR(ADDR), .CONV_CYCLES(64)) DUT (.mclk(mclk), .resetn(resetn),
		.sample_clk(sample_clk), .smb_scl_in(scl), .smb_sda_in(sda_line),
		.smb_sda_out(sda_out), .smb_sda_oe(sda_oe), .alert_n_in(alert_oe),
		.alert_n_out(alert_out), .alert_n_oe(alert_oe), .standby_request_n(standby_request_n_n),
		.fe_enable(fe_en), .fe_remote_sel(fe_rsel), .fe_valid(fe_valid),
		.fe_data(fe_data), .fe_open(fe_open));
	tmon_fe_model FE (.sample_clk(sample_clk), .fe_enable(fe_en), .fe_remote_sel(fe_rsel),
		.local_t(local_t), .remote_t(remote_t), .open_t(open_t), .fe_valid(fe_valid),
		.fe_data(fe_data),
		.fe_open(fe_open));
	// ----------------------------------------
	// smbus host tasks
	// ----------------------------------------
	task automatic half();
		repeat (6) @(negedge mclk);
	endtask
	// sda moves two cycles after scl falls so no false start is seen
	task automatic clk_bit(input logic b, output logic seen);
		repeat (2) @(negedge mclk);
		sda = b;
		half();
		scl = 1'b1;
		seen = sda_line;
		half();
		scl = 1'b0;
	endtask
	task automatic start();
		sda = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda = 1'b0;
		half();
		scl = 1'b0;
	endtask
	task automatic stop();
		repeat (2) @(negedge mclk);
		sda = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda = 1'b1;
		half();
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic send(input logic [7:0] b);
		logic seen;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], seen);
		clk_bit(1'b1, seen);
		chk("ack", 8'h00, {7'h00, seen});
	endtask
	task automatic recv(output logic [7:0] b);
		logic seen;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, seen);
			b[i] = seen;
		end
		clk_bit(1'b1, seen); // host nack ends the read
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start();
		send({ADDR, 1'b0});
		send(p);
		send(d);
		stop();
	endtask
	// pointer write, repeated start, one byte back; tried up to tries times
	task automatic rdchk(input logic [7:0] p, input logic [7:0] exp, input int tries);
		logic [7:0] d = ~exp;
		for (int n = 0; n < tries && d !== exp; n++)
		begin
			start();
			send({ADDR, 1'b0});
			send(p);
			start();
			send({ADDR, 1'b1});
			recv(d);
			stop();
		end
		chk($sformatf("reg %h", p), exp, d);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard
	initial
	begin
		repeat (90000) @(posedge mclk);
		failures++;
		print_verdict();
	end
	// ----------------------------------------
	// main sequence, powered up in standby
	// ----------------------------------------
	initial
	begin
		repeat (16) @(negedge mclk);
		resetn = 1'b1;
		repeat (8) @(negedge mclk);
		chk("alert", 8'h00, {7'h00, alert_oe});
		rdchk(RD_STATUS, 8'h28, 1);
		rdchk(RD_LOCAL, TEMP_RESET, 1);
		rdchk(RD_REMOTE, TEMP_RESET, 1);
		foreach (rst_val[i])
			rdchk(8'(i + 3), rst_val[i], 1);
		rdchk(WR_CONFIG, UNMAPPED_READ, 1);
		wr(WR_LOCAL_LO, 8'h80);
		wr(WR_REMOTE_LO, 8'h80);
		rdchk(RD_STATUS, 8'h28, 1);
		rdchk(RD_STATUS, 8'h00, 1);
		chk("alert", 8'h00, {7'h00, alert_oe});
		start();
		send({ALERT_RESPONSE_ADDR, 1'b1});
		recv(rdat);
		stop();
		chk("alert addr", {ADDR, 1'b0}, rdat);
		chk("alert", 8'h01, {7'h00, alert_oe});
		wr(WR_LOCAL_HI, 8'h10);
		wr(WR_RATE, 8'h05);
		rdchk(RD_RATE, 8'h05, 1);
		wr(WR_ONESHOT, 8'h00);
		rdchk(RD_REMOTE, TEMP_MIN_VALID, 40);
		rdchk(RD_LOCAL, 8'h19, 1);
		rdchk(RD_STATUS, 8'h40, 1);
		rdchk(RD_STATUS, 8'h40, 1);
		chk("alert", 8'h00, {7'h00, alert_oe});
		wr(WR_CONFIG, 8'h80);
		chk("alert", 8'h01, {7'h00, alert_oe});
		rdchk(RD_CONFIG, 8'h80, 1);
		local_t = 8'h05;
		standby_request_n_n = 1'b1;
		rdchk(RD_LOCAL, 8'h05, 40);
		wr(WR_CONFIG, 8'hc0);
		rdchk(RD_STATUS, 8'h00, 6);
		local_t = 8'h30;
		rdchk(RD_LOCAL, 8'h05, 1);
		open_t = 1'b1;
		wr(WR_ONESHOT, 8'h00);
		rdchk(RD_STATUS, 8'h44, 40);
		rdchk(RD_LOCAL, 8'h30, 1);
		print_verdict();
	end
endmodule

// [tb/tmon_fe_model.sv]
// tmon_fe_model.sv - behavioural front end that feeds samples to the core
// assumes: core raises fe_enable on sample_clk and takes one sample per fe_valid
`timescale 1ns/1ns
module tmon_fe_model (
	input wire logic sample_clk,
	input wire logic fe_enable,
	input wire logic fe_remote_sel,
	input wire logic [7:0] local_t,
	input wire logic [7:0] remote_t,
	input wire logic open_t,
	output logic fe_valid,
	output logic [7:0] fe_data,
	output logic fe_open
);
	logic odd = 1'b0; // picks t or t+1 for the next sample
	initial
	begin
		fe_valid = 1'b0;
		fe_data = 8'h00;
		fe_open = 1'b0;
	end
	// samples alternate t and t+1, so a rounding average would read t+1
	always @(posedge sample_clk)
	begin
		fe_valid <= fe_enable & ~fe_valid;
		if (fe_valid)
			odd <= ~odd;
		// data is only good with fe_valid; otherwise it keeps moving
		if (fe_enable & ~fe_valid)
		begin
			fe_data <= (fe_remote_sel ? remote_t : local_t) + {7'h00, odd};
			// open diode only shows on the remote channel
			fe_open <= fe_remote_sel & open_t;
		end
		else
			fe_data <= ~fe_data;
	end
endmodule
